// ### rtl/ift_pkg.sv
// shared constants and carrier types for the input fault threshold block
package ift_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int MV_W = 16;
    localparam int CODE_W = 8;
    localparam int CNT_W = 5;

    // register offsets
    localparam logic [7:0] TERM_BAT_OFFSET = 8'h47;
    localparam logic [7:0] GND_BIAS_OFFSET = 8'h48;
    localparam logic [7:0] DEBOUNCE_OFFSET = 8'h4a;
    localparam logic [7:0] RESERVED5_OFFSET = 8'h4b;
    localparam logic [7:0] BIAS_HIGH_OFFSET = 8'h4c;
    localparam logic [7:0] BIAS_LOW_OFFSET = 8'h4d;
    localparam logic [7:0] MONITOR_HIGH_OFFSET = 8'h4e;

    // reset values
    localparam logic [7:0] TERM_BAT_RESET = 8'h37;
    localparam logic [7:0] GND_BIAS_RESET = 8'h87;
    localparam logic [7:0] DEBOUNCE_RESET = 8'hb8;
    localparam logic [7:0] RESERVED5_RESET = 8'h00;
    localparam logic [7:0] BIAS_HIGH_RESET = 8'ha2;
    localparam logic [7:0] BIAS_LOW_RESET = 8'h48;
    localparam logic [7:0] MONITOR_HIGH_RESET = 8'hba;

    // field positions
    localparam int TERM_LSB = 4;
    localparam int BAT_LSB = 0;
    localparam int GND_LSB = 4;
    localparam int BIAS_LSB = 0;
    localparam int DBNC_SEL_LSB = 2;
    localparam int BAT_DBNC_BIT = 1;
    localparam int DOUBLE_BIT = 0;
    // only the low nibble of the debounce register is writable
    localparam logic [7:0] DEBOUNCE_WR_MASK = 8'h0f;

    // threshold steps in mV per code
    localparam logic [MV_W-1:0] STEP_30_MV = 16'h001e;
    localparam logic [MV_W-1:0] STEP_60_MV = 16'h003c;
    // thresholds of codes 13..10, packed high to low, mV
    localparam logic [4*MV_W-1:0] CUSTOM_30_MV = {16'h0186, 16'h0168, 16'h014a, 16'h012c};
    localparam logic [4*MV_W-1:0] CUSTOM_60_MV = {16'h030c, 16'h02d0, 16'h0294, 16'h0258};

    // debounce counts
    localparam logic [CNT_W-1:0] COUNT_16 = 5'h10;
    localparam logic [CNT_W-1:0] COUNT_8 = 5'h08;
    localparam logic [CNT_W-1:0] COUNT_4 = 5'h04;
    localparam logic [CNT_W-1:0] COUNT_1 = 5'h01;

    // one scan sample of the analog front end, all voltages in mV
    typedef struct packed {
        logic [MV_W-1:0] positive_input_pin;
        logic [MV_W-1:0] negative_input_pin;
        logic [MV_W-1:0] battery_sense_input;
        logic [MV_W-1:0] bias_supply;
        logic [CODE_W-1:0] bias_current_code;
        logic [CODE_W-1:0] analog_monitor_input;
    } ift_sample_t;

    typedef struct packed {
        logic terminal_short;
        logic battery_short;
        logic ground_short;
        logic bias_short;
        logic bias_high_current;
        logic bias_low_current;
        logic monitor_high;
        logic monitor_low;
    } ift_fault_t;

endpackage

// ### rtl/ift_threshold_decode.sv
// maps a four-bit short threshold code to millivolts, with optional doubling
module ift_threshold_decode #(
    parameter logic [ift_pkg::MV_W-1:0] STEP_MV = ift_pkg::STEP_30_MV,
    parameter logic [4*ift_pkg::MV_W-1:0] CUSTOM_MV = ift_pkg::CUSTOM_30_MV
) (
    input wire logic [3:0] code_in,
    input wire logic double_in,
    output logic [ift_pkg::MV_W-1:0] mv_out
);
    logic [ift_pkg::MV_W-1:0] base_mv;
    logic [1:0] custom_idx;

    always_comb begin
        custom_idx = code_in[1:0] - 2'h2;
        // codes 10..13 come from the trimmed table, all others are linear steps
        if (code_in >= 4'ha && code_in <= 4'hd) begin
            base_mv = CUSTOM_MV[custom_idx*ift_pkg::MV_W +: ift_pkg::MV_W];
        end else begin
            base_mv = ift_pkg::MV_W'({12'h000, code_in} * STEP_MV);
        end
        mv_out = double_in ? {base_mv[ift_pkg::MV_W-2:0], 1'b0} : base_mv;
    end
endmodule

// ### rtl/ift_debounce.sv
// counts consecutive out-of-threshold samples before declaring a fault
module ift_debounce (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic sample_in,
    input wire logic hit_in,
    input wire logic [ift_pkg::CNT_W-1:0] need_in,
    output logic fault_out
);
    logic [ift_pkg::CNT_W-1:0] count;
    logic [ift_pkg::CNT_W-1:0] next_count;
    logic next_fault;

    always_comb begin
        next_count = count;
        next_fault = fault_out;
        if (sample_in) begin
            if (!hit_in) begin
                next_count = '0;
                next_fault = 1'b0;
            end else if (count < need_in) begin
                next_count = count + 5'h01;
                next_fault = (count + 5'h01) >= need_in;
            end else begin
                next_fault = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count <= '0;
            fault_out <= 1'b0;
        end else begin
            count <= next_count;
            fault_out <= next_fault;
        end
    end
endmodule

// ### rtl/ift_fault_config.sv
// register bank and fault qualification for the input fault diagnostics

// Behaviour
// - the terminal short threshold code gives 30 mV steps, codes 10 to 13 use a trim table, reset code 3.
// - the battery short threshold code gives 30 mV steps, codes 10 to 13 use a trim table, reset code 7.
// - the ground short threshold code gives 60 mV steps up to 900 mV and resets to code 8.
// - the bias short threshold code gives 30 mV steps, codes 10 to 13 use a trim table.
// - the debounce selection asks 16, 8, 4 or 1 consecutive detections, battery shorts below bias excepted.
// - the battery short debounce bit asks 16 detections when clear and 8 when set.
// - the doubling bit multiplies every configured threshold by two.
// - the bias high current limit is an eight-bit code compared with the current code, reset 0xa2.
// - the bias low current limit uses the same code scale, reset 0x48.
// - the analog monitor high limit is an eight-bit code compared with the monitor input, reset 0xba.
// - the registers reset to 0x37, 0x87, 0xb8 and 0x00 for the reserved register.
// - analog monitor high and low crossings are reported as separate live indications.
// - bias high and low current faults are reported as separate live indications.
module ift_fault_config (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic [ift_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [ift_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [ift_pkg::DATA_W-1:0] reg_rdata_out,
    output logic reg_rvalid_out,
    input wire logic sample_valid_in,
    input wire ift_pkg::ift_sample_t sample_in,
    input wire logic [ift_pkg::CODE_W-1:0] analog_monitor_low_limit_in,
    output ift_pkg::ift_fault_t fault_out,
    output logic [ift_pkg::DATA_W-1:0] live_interrupt_status_two_out
);
    logic [7:0] terminal_and_battery_short_threshold;
    logic [7:0] ground_and_bias_short_threshold;
    logic [7:0] fault_debounce_and_scale;
    logic [7:0] bias_high_current_threshold;
    logic [7:0] bias_low_current_threshold;
    logic [7:0] analog_monitor_high_threshold;
    logic [7:0] next_term_bat;
    logic [7:0] next_gnd_bias;
    logic [7:0] next_debounce;
    logic [7:0] next_bias_high;
    logic [7:0] next_bias_low;
    logic [7:0] next_monitor_high;
    logic [7:0] next_rdata;
    logic next_rvalid;

    logic [3:0] terminal_short_threshold;
    logic [3:0] battery_short_threshold;
    logic [3:0] ground_short_threshold;
    logic [3:0] bias_short_threshold;
    logic [1:0] fault_debounce_select;
    logic battery_short_debounce;
    logic threshold_double_scale;

    logic [ift_pkg::MV_W-1:0] term_mv;
    logic [ift_pkg::MV_W-1:0] bat_mv;
    logic [ift_pkg::MV_W-1:0] gnd_mv;
    logic [ift_pkg::MV_W-1:0] bias_mv;
    logic [ift_pkg::MV_W-1:0] diff_mv;
    logic [ift_pkg::MV_W-1:0] bat_gap_mv;
    logic [ift_pkg::MV_W-1:0] bias_gap_mv;
    logic [8:0] bias_high_limit;
    logic [8:0] bias_low_limit;
    logic [8:0] monitor_high_limit;
    logic [8:0] monitor_low_limit;
    logic [ift_pkg::CNT_W-1:0] general_need;
    logic [ift_pkg::CNT_W-1:0] battery_need;
    logic battery_below_bias;
    ift_pkg::ift_fault_t hit;
    ift_pkg::ift_fault_t debounced;
    logic [8*ift_pkg::CNT_W-1:0] need_vec;

    // register fields
    always_comb begin
        terminal_short_threshold = terminal_and_battery_short_threshold[ift_pkg::TERM_LSB +: 4];
        battery_short_threshold = terminal_and_battery_short_threshold[ift_pkg::BAT_LSB +: 4];
        ground_short_threshold = ground_and_bias_short_threshold[ift_pkg::GND_LSB +: 4];
        bias_short_threshold = ground_and_bias_short_threshold[ift_pkg::BIAS_LSB +: 4];
        fault_debounce_select = fault_debounce_and_scale[ift_pkg::DBNC_SEL_LSB +: 2];
        battery_short_debounce = fault_debounce_and_scale[ift_pkg::BAT_DBNC_BIT];
        threshold_double_scale = fault_debounce_and_scale[ift_pkg::DOUBLE_BIT];
    end

    // register writes and registered read data
    always_comb begin
        next_term_bat = terminal_and_battery_short_threshold;
        next_gnd_bias = ground_and_bias_short_threshold;
        next_debounce = fault_debounce_and_scale;
        next_bias_high = bias_high_current_threshold;
        next_bias_low = bias_low_current_threshold;
        next_monitor_high = analog_monitor_high_threshold;
        if (reg_write_in) begin
            unique case (reg_addr_in)
                ift_pkg::TERM_BAT_OFFSET: next_term_bat = reg_wdata_in;
                ift_pkg::GND_BIAS_OFFSET: next_gnd_bias = reg_wdata_in;
                ift_pkg::DEBOUNCE_OFFSET: begin
                    // reserved upper bits keep their reset value whatever is written
                    next_debounce = (ift_pkg::DEBOUNCE_RESET & ~ift_pkg::DEBOUNCE_WR_MASK)
                        | (reg_wdata_in & ift_pkg::DEBOUNCE_WR_MASK);
                end
                ift_pkg::BIAS_HIGH_OFFSET: next_bias_high = reg_wdata_in;
                ift_pkg::BIAS_LOW_OFFSET: next_bias_low = reg_wdata_in;
                ift_pkg::MONITOR_HIGH_OFFSET: next_monitor_high = reg_wdata_in;
                default: begin
                    // the reserved register and unmapped offsets ignore writes
                end
            endcase
        end
        next_rvalid = reg_read_in;
        next_rdata = reg_rdata_out;
        if (reg_read_in) begin
            unique case (reg_addr_in)
                ift_pkg::TERM_BAT_OFFSET: next_rdata = terminal_and_battery_short_threshold;
                ift_pkg::GND_BIAS_OFFSET: next_rdata = ground_and_bias_short_threshold;
                ift_pkg::DEBOUNCE_OFFSET: next_rdata = fault_debounce_and_scale;
                ift_pkg::RESERVED5_OFFSET: next_rdata = ift_pkg::RESERVED5_RESET;
                ift_pkg::BIAS_HIGH_OFFSET: next_rdata = bias_high_current_threshold;
                ift_pkg::BIAS_LOW_OFFSET: next_rdata = bias_low_current_threshold;
                ift_pkg::MONITOR_HIGH_OFFSET: next_rdata = analog_monitor_high_threshold;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            terminal_and_battery_short_threshold <= ift_pkg::TERM_BAT_RESET;
            ground_and_bias_short_threshold <= ift_pkg::GND_BIAS_RESET;
            fault_debounce_and_scale <= ift_pkg::DEBOUNCE_RESET;
            bias_high_current_threshold <= ift_pkg::BIAS_HIGH_RESET;
            bias_low_current_threshold <= ift_pkg::BIAS_LOW_RESET;
            analog_monitor_high_threshold <= ift_pkg::MONITOR_HIGH_RESET;
            reg_rdata_out <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            terminal_and_battery_short_threshold <= next_term_bat;
            ground_and_bias_short_threshold <= next_gnd_bias;
            fault_debounce_and_scale <= next_debounce;
            bias_high_current_threshold <= next_bias_high;
            bias_low_current_threshold <= next_bias_low;
            analog_monitor_high_threshold <= next_monitor_high;
            reg_rdata_out <= next_rdata;
            reg_rvalid_out <= next_rvalid;
        end
    end

    // threshold decoders
    ift_threshold_decode #(
        .STEP_MV(ift_pkg::STEP_30_MV),
        .CUSTOM_MV(ift_pkg::CUSTOM_30_MV)
    ) u_term_decode (
        .code_in(terminal_short_threshold),
        .double_in(threshold_double_scale),
        .mv_out(term_mv)
    );

    ift_threshold_decode #(
        .STEP_MV(ift_pkg::STEP_30_MV),
        .CUSTOM_MV(ift_pkg::CUSTOM_30_MV)
    ) u_bat_decode (
        .code_in(battery_short_threshold),
        .double_in(threshold_double_scale),
        .mv_out(bat_mv)
    );

    ift_threshold_decode #(
        .STEP_MV(ift_pkg::STEP_60_MV),
        .CUSTOM_MV(ift_pkg::CUSTOM_60_MV)
    ) u_gnd_decode (
        .code_in(ground_short_threshold),
        .double_in(threshold_double_scale),
        .mv_out(gnd_mv)
    );

    ift_threshold_decode #(
        .STEP_MV(ift_pkg::STEP_30_MV),
        .CUSTOM_MV(ift_pkg::CUSTOM_30_MV)
    ) u_bias_decode (
        .code_in(bias_short_threshold),
        .double_in(threshold_double_scale),
        .mv_out(bias_mv)
    );

    // raw comparisons against the scaled thresholds
    always_comb begin
        // code limits gain one bit so that doubling never wraps
        bias_high_limit = threshold_double_scale ?
            {bias_high_current_threshold, 1'b0} : {1'b0, bias_high_current_threshold};
        bias_low_limit = threshold_double_scale ?
            {bias_low_current_threshold, 1'b0} : {1'b0, bias_low_current_threshold};
        monitor_high_limit = threshold_double_scale ?
            {analog_monitor_high_threshold, 1'b0} : {1'b0, analog_monitor_high_threshold};
        monitor_low_limit = threshold_double_scale ?
            {analog_monitor_low_limit_in, 1'b0} : {1'b0, analog_monitor_low_limit_in};
        diff_mv = (sample_in.positive_input_pin >= sample_in.negative_input_pin) ?
            sample_in.positive_input_pin - sample_in.negative_input_pin :
            sample_in.negative_input_pin - sample_in.positive_input_pin;
        // a pin above its rail counts as a zero gap
        bat_gap_mv = (sample_in.battery_sense_input > sample_in.positive_input_pin) ?
            sample_in.battery_sense_input - sample_in.positive_input_pin : '0;
        bias_gap_mv = (sample_in.bias_supply > sample_in.positive_input_pin) ?
            sample_in.bias_supply - sample_in.positive_input_pin : '0;
        hit.terminal_short = diff_mv <= term_mv;
        hit.battery_short = bat_gap_mv <= bat_mv;
        hit.ground_short = sample_in.positive_input_pin <= gnd_mv;
        hit.bias_short = bias_gap_mv <= bias_mv;
        hit.bias_high_current = {1'b0, sample_in.bias_current_code} > bias_high_limit;
        hit.bias_low_current = {1'b0, sample_in.bias_current_code} < bias_low_limit;
        hit.monitor_high = {1'b0, sample_in.analog_monitor_input} > monitor_high_limit;
        hit.monitor_low = {1'b0, sample_in.analog_monitor_input} < monitor_low_limit;
    end

    // debounce depth selection
    always_comb begin
        unique case (fault_debounce_select)
            2'h0: general_need = ift_pkg::COUNT_16;
            2'h1: general_need = ift_pkg::COUNT_8;
            2'h2: general_need = ift_pkg::COUNT_4;
            2'h3: general_need = ift_pkg::COUNT_1;
        endcase
        battery_need = battery_short_debounce ? ift_pkg::COUNT_8 : ift_pkg::COUNT_16;
        battery_below_bias = sample_in.battery_sense_input < sample_in.bias_supply;
        need_vec = {8{general_need}};
        // struct bit 6 is the battery short, which has its own depth below the bias rail
        if (battery_below_bias) begin
            need_vec[6*ift_pkg::CNT_W +: ift_pkg::CNT_W] = battery_need;
        end
    end

    for (genvar i = 0; i < 8; i++) begin : g_debounce
        ift_debounce u_debounce (
            .sys_clk_in(sys_clk_in),
            .rstn_in(rstn_in),
            .sample_in(sample_valid_in),
            .hit_in(hit[i]),
            .need_in(need_vec[i*ift_pkg::CNT_W +: ift_pkg::CNT_W]),
            .fault_out(debounced[i])
        );
    end

    // live indications follow the debounced faults, each on its own bit
    always_comb begin
        fault_out = debounced;
        live_interrupt_status_two_out = {
            debounced.monitor_high,
            debounced.monitor_low,
            3'h0,
            debounced.bias_high_current,
            debounced.bias_low_current,
            1'b0
        };
    end
endmodule

// ### verification/ift_fault_config_checker.sv
// concurrent port checks for the input fault threshold register bank
module ift_fault_config_checker (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic [ift_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [ift_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [ift_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    input wire logic sample_valid_in,
    input wire ift_pkg::ift_sample_t sample_in,
    input wire logic [ift_pkg::CODE_W-1:0] analog_monitor_low_limit_in,
    input wire ift_pkg::ift_fault_t fault_out,
    input wire logic [ift_pkg::DATA_W-1:0] live_interrupt_status_two_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rstn_in);

    property p_read_answer; reg_read_in |=> reg_rvalid_out; endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_read_quiet; !reg_read_in |=> !reg_rvalid_out && $stable(reg_rdata_out); endproperty
    a_read_quiet: assert property (p_read_quiet) else $error("read data moved unasked");
    property p_unmapped;
        reg_read_in && !(reg_addr_in inside {8'h47, 8'h48, 8'h4a, 8'h4c, 8'h4d, 8'h4e})
            |=> reg_rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_debounce_fixed; reg_read_in && reg_addr_in == 8'h4a |=> reg_rdata_out[7:4] == 4'hb; endproperty
    a_debounce_fixed: assert property (p_debounce_fixed) else $error("reserved bits moved");
    // the idle cycle between write and read matches the bench's bus tasks
    property p_write_back;
        reg_write_in && !reg_read_in && reg_addr_in == 8'h4c ##1 !reg_write_in
            ##1 reg_read_in && !reg_write_in && reg_addr_in == 8'h4c
            |=> reg_rdata_out == $past(reg_wdata_in, 3);
    endproperty
    a_write_back: assert property (p_write_back) else $error("limit write lost");
    property p_fault_hold; !sample_valid_in |=> $stable(fault_out); endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault moved without sample");
    property p_monitor_live;
        live_interrupt_status_two_out[7:6] == {fault_out.monitor_high, fault_out.monitor_low};
    endproperty
    a_monitor_live: assert property (p_monitor_live) else $error("monitor live bits wrong");
    property p_bias_live;
        live_interrupt_status_two_out[5:0] ==
            {3'b000, fault_out.bias_high_current, fault_out.bias_low_current, 1'b0};
    endproperty
    a_bias_live: assert property (p_bias_live) else $error("bias live bits wrong");
    // clean even against a doubled limit, so the doubling bit need not be known here
    property p_low_clear;
        sample_valid_in && {1'b0, sample_in.analog_monitor_input} >= {analog_monitor_low_limit_in, 1'b0}
            |=> !fault_out.monitor_low;
    endproperty
    a_low_clear: assert property (p_low_clear) else $error("monitor low not cleared");
endmodule

bind ift_fault_config ift_fault_config_checker u_checker (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .sample_valid_in(sample_valid_in), .sample_in(sample_in),
    .analog_monitor_low_limit_in(analog_monitor_low_limit_in), .fault_out(fault_out),
    .live_interrupt_status_two_out(live_interrupt_status_two_out)
);

// ### verification/ift_fault_config_bench.sv
// self-checking bench for the input fault threshold register bank
`define CHK(got, want) begin checks++; if ((got) !== (want)) begin n_mismatch++; \
    $display("Error %0t: got %h want %h", $time, got, want); end end
module ift_fault_config_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_write_in = 1'b0;
    logic reg_read_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic reg_rvalid_out;
    logic sample_valid_in = 1'b0;
    ift_pkg::ift_sample_t sample_in = '0;
    logic [7:0] analog_monitor_low_limit_in = 8'h20;
    ift_pkg::ift_fault_t fault_out;
    logic [7:0] live_interrupt_status_two_out;
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;

    ift_fault_config DUT (
        .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
        .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
        .sample_valid_in(sample_valid_in), .sample_in(sample_in),
        .analog_monitor_low_limit_in(analog_monitor_low_limit_in), .fault_out(fault_out),
        .live_interrupt_status_two_out(live_interrupt_status_two_out)
    );

    initial begin
        forever #10 sys_clk_in = ~sys_clk_in;
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // the run needs well under a thousand cycles
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            finish_test();
        end
    end

    // each bus task ends with an idle edge so a strobe is never dropped and raised at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_write_in = 1'b1;
        @(posedge sys_clk_in);
        #2 reg_write_in = 1'b0;
        @(posedge sys_clk_in);
        #2;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] want);
        reg_addr_in = a;
        reg_read_in = 1'b1;
        @(posedge sys_clk_in);
        #2 reg_read_in = 1'b0;
        `CHK(reg_rvalid_out, 1'b1)
        `CHK(reg_rdata_out, want)
        @(posedge sys_clk_in);
        #2;
    endtask

    // n identical samples, one idle edge, then one fault bit (7 terminal .. 0 monitor low)
    task automatic probe(input int n, input logic [15:0] p, m, bat, bias,
        input logic [7:0] cur, mon, input int idx, input logic want);
        logic [7:0] fv;
        sample_in = '{p, m, bat, bias, cur, mon};
        for (int i = 0; i < n; i++) begin
            sample_valid_in = 1'b1;
            @(posedge sys_clk_in);
            #2;
        end
        sample_valid_in = 1'b0;
        @(posedge sys_clk_in);
        #2 fv = fault_out;
        `CHK(fv[idx], want)
    endtask

    task automatic t_reset;
        rd(8'h47, 8'h37);
        rd(8'h48, 8'h87);
        rd(8'h4a, 8'hb8);
        rd(8'h4b, 8'h00);
        rd(8'h4c, 8'ha2);
        rd(8'h4d, 8'h48);
        rd(8'h4e, 8'hba);
        rd(8'h49, 8'h00);
        $display("t_reset done");
    endtask

    task automatic t_regs;
        wr(8'h47, 8'h5a);
        rd(8'h47, 8'h5a);
        wr(8'h48, 8'hc3);
        rd(8'h48, 8'hc3);
        wr(8'h4a, 8'hbf);
        rd(8'h4a, 8'hbf);
        wr(8'h4a, 8'hb0);
        rd(8'h4a, 8'hb0);
        wr(8'h4b, 8'h00);
        rd(8'h4b, 8'h00);
        wr(8'h4c, 8'h60);
        rd(8'h4c, 8'h60);
        wr(8'h4d, 8'h40);
        rd(8'h4d, 8'h40);
        wr(8'h4e, 8'h90);
        rd(8'h4e, 8'h90);
        wr(8'h49, 8'hff);
        rd(8'h49, 8'h00);
        $display("t_regs done");
    endtask

    task automatic t_debounce;
        int need;
        wr(8'h47, 8'h10);
        for (int s = 0; s < 4; s++) begin
            need = (s == 3) ? 1 : 16 >> s;
            wr(8'h4a, 8'hb0 | 8'(s << 2));
            probe(need - 1, 16'd2000, 16'd2000, 16'd0, 16'd0, 8'h50, 8'h50, 7, 1'b0);
            probe(1, 16'd2000, 16'd2100, 16'd0, 16'd0, 8'h50, 8'h50, 7, 1'b0);
            probe(need - 1, 16'd2000, 16'd2000, 16'd0, 16'd0, 8'h50, 8'h50, 7, 1'b0);
            probe(1, 16'd2000, 16'd2000, 16'd0, 16'd0, 8'h50, 8'h50, 7, 1'b1);
            probe(1, 16'd2000, 16'd2100, 16'd0, 16'd0, 8'h50, 8'h50, 7, 1'b0);
        end
        $display("t_debounce done");
    endtask

    task automatic t_thresh;
        wr(8'h4a, 8'hbc);
        wr(8'h47, 8'h1f);
        wr(8'h48, 8'hfe);
        probe(1, 16'd2000, 16'd2030, 16'd0, 16'd0, 8'h50, 8'h50, 7, 1'b1);
        probe(1, 16'd2000, 16'd2031, 16'd0, 16'd0, 8'h50, 8'h50, 7, 1'b0);
        probe(1, 16'd2000, 16'd2000, 16'd2450, 16'd0, 8'h50, 8'h50, 6, 1'b1);
        probe(1, 16'd2000, 16'd2000, 16'd2451, 16'd0, 8'h50, 8'h50, 6, 1'b0);
        probe(1, 16'd900, 16'd900, 16'd0, 16'd0, 8'h50, 8'h50, 5, 1'b1);
        probe(1, 16'd901, 16'd901, 16'd0, 16'd0, 8'h50, 8'h50, 5, 1'b0);
        probe(1, 16'd2000, 16'd2000, 16'd0, 16'd2420, 8'h50, 8'h50, 4, 1'b1);
        probe(1, 16'd2000, 16'd2000, 16'd0, 16'd2421, 8'h50, 8'h50, 4, 1'b0);
        wr(8'h4a, 8'hbd);
        probe(1, 16'd2000, 16'd2060, 16'd0, 16'd0, 8'h50, 8'h50, 7, 1'b1);
        probe(1, 16'd2000, 16'd2061, 16'd0, 16'd0, 8'h50, 8'h50, 7, 1'b0);
        probe(1, 16'd1800, 16'd1800, 16'd0, 16'd0, 8'h50, 8'h50, 5, 1'b1);
        probe(1, 16'd1801, 16'd1801, 16'd0, 16'd0, 8'h50, 8'h50, 5, 1'b0);
        wr(8'h4a, 8'hbc);
        wr(8'h47, 8'hae);
        probe(1, 16'd2000, 16'd2300, 16'd0, 16'd0, 8'h50, 8'h50, 7, 1'b1);
        probe(1, 16'd2000, 16'd2301, 16'd0, 16'd0, 8'h50, 8'h50, 7, 1'b0);
        probe(1, 16'd2000, 16'd2000, 16'd2420, 16'd0, 8'h50, 8'h50, 6, 1'b1);
        probe(1, 16'd2000, 16'd2000, 16'd2421, 16'd0, 8'h50, 8'h50, 6, 1'b0);
        $display("t_thresh done");
    endtask

    task automatic t_limits;
        probe(1, 16'd2000, 16'd2000, 16'd0, 16'd0, 8'h61, 8'h50, 3, 1'b1);
        probe(1, 16'd2000, 16'd2000, 16'd0, 16'd0, 8'h60, 8'h50, 3, 1'b0);
        probe(1, 16'd2000, 16'd2000, 16'd0, 16'd0, 8'h3f, 8'h50, 2, 1'b1);
        `CHK(live_interrupt_status_two_out, 8'h02)
        probe(1, 16'd2000, 16'd2000, 16'd0, 16'd0, 8'h40, 8'h50, 2, 1'b0);
        probe(1, 16'd2000, 16'd2000, 16'd0, 16'd0, 8'h50, 8'h91, 1, 1'b1);
        `CHK(live_interrupt_status_two_out, 8'h80)
        probe(1, 16'd2000, 16'd2000, 16'd0, 16'd0, 8'h50, 8'h90, 1, 1'b0);
        probe(1, 16'd2000, 16'd2000, 16'd0, 16'd0, 8'h50, 8'h1f, 0, 1'b1);
        probe(1, 16'd2000, 16'd2000, 16'd0, 16'd0, 8'h50, 8'h20, 0, 1'b0);
        wr(8'h4a, 8'hbd);
        probe(1, 16'd2000, 16'd2000, 16'd0, 16'd0, 8'hc1, 8'h50, 3, 1'b1);
        probe(1, 16'd2000, 16'd2000, 16'd0, 16'd0, 8'hc0, 8'h50, 3, 1'b0);
        $display("t_limits done");
    endtask

    // battery below bias supply takes its own depth even with no general debounce
    task automatic t_bat;
        wr(8'h4a, 8'hbc);
        wr(8'h47, 8'h0f);
        // earlier scenarios leave the battery count running, so restart it first
        probe(1, 16'd2000, 16'd2100, 16'd2500, 16'd3000, 8'h50, 8'h50, 6, 1'b0);
        probe(15, 16'd2000, 16'd2100, 16'd2100, 16'd3000, 8'h50, 8'h50, 6, 1'b0);
        probe(1, 16'd2000, 16'd2100, 16'd2100, 16'd3000, 8'h50, 8'h50, 6, 1'b1);
        probe(1, 16'd2000, 16'd2100, 16'd2500, 16'd3000, 8'h50, 8'h50, 6, 1'b0);
        wr(8'h4a, 8'hbe);
        probe(7, 16'd2000, 16'd2100, 16'd2100, 16'd3000, 8'h50, 8'h50, 6, 1'b0);
        probe(1, 16'd2000, 16'd2100, 16'd2100, 16'd3000, 8'h50, 8'h50, 6, 1'b1);
        $display("t_bat done");
    endtask

    initial begin
        repeat (2) @(posedge sys_clk_in);
        #2 rstn_in = 1'b1;
        t_reset();
        t_regs();
        t_debounce();
        t_thresh();
        t_limits();
        t_bat();
        finish_test();
    end
endmodule
